// File: hw/pwr_cmd_pkg.sv
// constants and types for the thermal/turn-on command bank
// assumes a 250 MHz ref_clk and one-degree / one-millisecond linear units
package pwr_cmd_pkg;
   // command codes
   localparam logic [7:0] CMD_FAULT_RESPONSE = 8'h50;
   localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;
   localparam logic [7:0] CMD_TURN_ON_WAIT = 8'h60;
   localparam logic [7:0] CMD_RAMP_TIME = 8'h61;

   // word layout: exponent [15:11] fixed zero, mantissa [10:0]
   localparam int MANT_W = 11;
   localparam int PROG_W = 7;
   localparam int TEMP_W = 11;
   localparam int MS_W = 10;

   // fault-response bit positions
   localparam int RSP_BIT = 7;
   localparam int RS_BIT = 5;
   localparam logic [2:0] RS_NONE = 3'h0;
   localparam logic [2:0] RS_ALL = 3'h7;

   // reset values and limits
   localparam logic [TEMP_W-1:0] WARN_RESET = 11'h078;
   localparam logic [TEMP_W-1:0] WARN_MIN = 11'h064;
   localparam logic [TEMP_W-1:0] WARN_MAX = 11'h08c;
   localparam logic [TEMP_W-1:0] WARN_BELOW_FAULT = 11'h019;
   localparam logic [TEMP_W-1:0] WARN_HYST = 11'h014;
   localparam logic [PROG_W-1:0] WAIT_RESET = 7'h00;
   localparam logic [PROG_W-1:0] RAMP_RESET = 7'h03;
   localparam logic [7:0] RESP_RESET = 8'hbf;
   localparam logic [MS_W-1:0] RETRY_PERIODS = 10'h007;
   localparam logic [1:0] INIT_SETTLE = 2'h3;

   // times in their own units, cycle counts derived from the clock period
   localparam int CLK_PERIOD_PS = 4000;
   localparam int MS_TIME_US = 1000;
   localparam int SHORT_WAIT_US = 50;
   localparam int CYC_PER_MS = (MS_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int CYC_SHORT_WAIT = (SHORT_WAIT_US * 1000000) / CLK_PERIOD_PS;

   // one command transaction from the bus engine
   typedef struct packed {
      logic write;
      logic [7:0] code;
      logic [15:0] wdata;
   } cmd_req_s;

   // sticky status seen by the host
   typedef struct packed {
      logic temp_summary;
      logic warn_status;
      logic comm_fault_summary_bit;
      logic invalid_data;
      logic invalid_command_fault;
   } status_s;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_WAIT = 3'b001,
      ST_RAMP = 3'b010,
      ST_ON = 3'b011,
      ST_RETRY = 3'b100,
      ST_LATCHED = 3'b101
   } seq_e;
endpackage : pwr_cmd_pkg

// File: hw/ms_tick_div.sv
// millisecond enable divider for the sequencer timers
// assumes clr is a same-clock pulse that restarts the count
`timescale 1ns/1ps
module ms_tick_div #(
   parameter int DIV = 250000
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // control
   input wire logic clr,
   output logic tick
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic nxt_tick;
   logic tick_ff;

   // count to DIV-1 then emit one enable
   always_comb begin
      nxt_tick = 1'b0;
      nxt_cnt = cnt_ff + 32'h1;
      if (clr) begin
         nxt_cnt = 32'h0;
      end else if (cnt_ff == 32'(DIV - 1)) begin
         nxt_cnt = 32'h0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 32'h0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule : ms_tick_div

// File: hw/time_bucket.sv
// maps a programmed millisecond mantissa onto one of the 16 supported times
// pure combinational; ramp mode floors everything at 1 ms
`timescale 1ns/1ps
module time_bucket
   import pwr_cmd_pkg::*;
(
   // programmed value
   input wire logic [PROG_W-1:0] mant,
   input wire logic ramp_mode,
   // effective time in ms, zero means the short 50 us wait
   output logic [PROG_W-1:0] eff_ms
);
   // breakpoints shared by turn-on wait and ramp time
   always_comb begin
      if (mant <= 7'h06) begin
         eff_ms = mant;
      end else if (mant <= 7'h09) begin
         eff_ms = 7'h07;
      end else if (mant <= 7'h0c) begin
         eff_ms = 7'h0a;
      end else if (mant <= 7'h11) begin
         eff_ms = 7'h0e;
      end else if (mant <= 7'h16) begin
         eff_ms = 7'h13;
      end else if (mant <= 7'h20) begin
         eff_ms = 7'h1b;
      end else if (mant <= 7'h2c) begin
         eff_ms = 7'h25;
      end else if (mant <= 7'h3e) begin
         eff_ms = 7'h34;
      end else if (mant <= 7'h56) begin
         eff_ms = 7'h48;
      end else begin
         eff_ms = 7'h64;
      end
      if (ramp_mode && (mant <= 7'h01)) begin
         eff_ms = 7'h01;
      end
   end
endmodule : time_bucket

// File: hw/thermal_turn_on_regs.sv
// command bank: fault-response retry code, thermal warning threshold,
// turn-on wait and ramp time, plus the start/ramp/retry sequencer they steer
// assumes a same-clock command engine that hands over decoded word transactions
// Operation
// - wait code 000: no restart, stay off
// - wait code 111: seven ramp periods, restart
// - wait bits read back as bit 5
// - over warning: status bits and alert
// - warning clears 20 degrees below threshold
// - warning at/above fault refused, flagged
// - bypass bit accepts high warning threshold
// - warning default is fault minus 25, floor 100
// - warning exponent zero, mantissa default 120
// - warning mantissa spans 100 to 140
// - turn-on wait from start to rise
// - wait and ramp saved on save-all
// - loop slave refuses wait/ramp commands
// - wait: 1 ms unit, seven bits, default 0
// - wait quantized into 16 buckets
// - ramp time runs from rise to regulation
// - ramp zero means 1 ms ramp
// - soft-start resistor sets ramp at power-up
// - ramp: seven bits, 1 ms unit, default 3
// - ramp buckets same, floor 1 ms
// - loop slave ramp fixed at 100 ms
`timescale 1ns/1ps
module thermal_turn_on_regs
   import pwr_cmd_pkg::*;
#(
   parameter int MS_CYCLES = CYC_PER_MS,
   parameter int SHORT_CYCLES = CYC_SHORT_WAIT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // command transactions
   input wire logic cmd_valid,
   input wire cmd_req_s cmd_req,
   output logic cmd_done,
   output logic cmd_nack,
   output logic [15:0] cmd_rdata,
   // temperature and neighbouring settings
   input wire logic [TEMP_W-1:0] sensed_temp,
   input wire logic [TEMP_W-1:0] thermal_fault_threshold,
   input wire logic limit_check_bypass,
   input wire logic thermal_fault_level,
   input wire logic clear_faults,
   // pins
   input wire logic start_pin,
   input wire logic loop_slave_pin,
   input wire logic ss_pin_high,
   input wire logic [PROG_W-1:0] ss_mantissa,
   // nonvolatile save
   input wire logic save_all_defaults,
   output logic nvm_save,
   output logic [2*PROG_W-1:0] nvm_data,
   // status and sequencing
   output status_s status,
   output logic thermal_warning_level,
   output logic smbalert,
   output logic out_enable,
   output logic ramp_active,
   output logic in_regulation
);
   // pin synchronisers
   logic [2:0] pin_meta_ff;
   logic [2:0] pin_sync_ff;
   logic start_s;
   logic loop_s;
   logic ss_high_s;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_ff <= 3'h0;
         pin_sync_ff <= 3'h0;
      end else begin
         pin_meta_ff <= {ss_pin_high, loop_slave_pin, start_pin};
         pin_sync_ff <= pin_meta_ff;
      end
   end
   assign start_s = pin_sync_ff[0];
   assign loop_s = pin_sync_ff[1];
   assign ss_high_s = pin_sync_ff[2];

   // register state
   logic [TEMP_W-1:0] warn_ff, nxt_warn;
   logic [PROG_W-1:0] wait_ff, nxt_wait;
   logic [PROG_W-1:0] ramp_ff, nxt_ramp;
   logic rsp_ff, nxt_rsp;
   logic rs_ff, nxt_rs;
   logic [1:0] init_ff, nxt_init;
   logic loop_ff, nxt_loop;
   status_s stat_ff, nxt_stat;
   logic warn_lvl_ff, nxt_warn_lvl;
   logic done_ff, nxt_done;
   logic nack_ff, nxt_nack;
   logic [15:0] rdata_ff, nxt_rdata;
   logic save_ff, nxt_save;
   logic [2*PROG_W-1:0] nvm_ff, nxt_nvm;
   logic alert_ff, nxt_alert;

   // default warning threshold from the stored fault threshold
   logic [TEMP_W-1:0] warn_default;
   always_comb begin
      if (thermal_fault_threshold < (WARN_MIN + WARN_BELOW_FAULT)) begin
         warn_default = WARN_MIN;
      end else begin
         warn_default = thermal_fault_threshold - WARN_BELOW_FAULT;
      end
   end

   // hysteresis low point, guarded against underflow
   logic [TEMP_W-1:0] warn_release;
   assign warn_release = (warn_ff > WARN_HYST) ? (warn_ff - WARN_HYST) : '0;

   // command decode, register writes and sticky status
   logic [TEMP_W-1:0] wr_mant;
   logic [2:0] wr_rs;
   logic timing_cmd;
   logic warn_rise;
   assign wr_mant = cmd_req.wdata[TEMP_W-1:0];
   assign wr_rs = cmd_req.wdata[RS_BIT:RS_BIT-2];
   assign timing_cmd = (cmd_req.code == CMD_TURN_ON_WAIT) || (cmd_req.code == CMD_RAMP_TIME);
   assign warn_rise = !warn_lvl_ff && (sensed_temp > warn_ff);

   always_comb begin
      nxt_warn = warn_ff;
      nxt_wait = wait_ff;
      nxt_ramp = ramp_ff;
      nxt_rsp = rsp_ff;
      nxt_rs = rs_ff;
      nxt_init = init_ff;
      nxt_loop = loop_ff;
      nxt_stat = stat_ff;
      nxt_warn_lvl = warn_lvl_ff;
      nxt_done = 1'b0;
      nxt_nack = 1'b0;
      nxt_rdata = rdata_ff;
      nxt_save = 1'b0;
      nxt_nvm = nvm_ff;
      // power-up: straps settle through the synchroniser, then defaults load
      if (init_ff != INIT_SETTLE) begin
         nxt_init = init_ff + 2'h1;
         if (init_ff == INIT_SETTLE - 2'h1) begin
            nxt_warn = warn_default;
            nxt_loop = loop_s;
            if (!ss_high_s) begin
               nxt_ramp = ss_mantissa;
            end
         end
      end
      if (clear_faults) begin
         nxt_stat = '0;
      end
      // warning level with hysteresis
      if (warn_rise) begin
         nxt_warn_lvl = 1'b1;
      end else if (warn_lvl_ff && (sensed_temp <= warn_release)) begin
         nxt_warn_lvl = 1'b0;
      end
      if (warn_rise) begin
         nxt_stat.temp_summary = 1'b1;
         nxt_stat.warn_status = 1'b1;
      end
      if (cmd_valid && (init_ff == INIT_SETTLE)) begin
         nxt_done = 1'b1;
         if (loop_ff && timing_cmd) begin
            nxt_nack = 1'b1;
            nxt_stat.invalid_command_fault = 1'b1;
            nxt_stat.comm_fault_summary_bit = 1'b1;
         end else if (!cmd_req.write) begin
            case (cmd_req.code)
               CMD_FAULT_RESPONSE: nxt_rdata = {8'h00, rsp_ff, 1'b0, {6{rs_ff}}};
               CMD_WARN_LIMIT: nxt_rdata = {5'h00, warn_ff};
               CMD_TURN_ON_WAIT: nxt_rdata = {9'h000, wait_ff};
               CMD_RAMP_TIME: nxt_rdata = {9'h000, ramp_ff};
               default: begin
                  nxt_nack = 1'b1;
                  nxt_stat.invalid_command_fault = 1'b1;
                  nxt_stat.comm_fault_summary_bit = 1'b1;
               end
            endcase
         end else begin
            case (cmd_req.code)
               CMD_FAULT_RESPONSE: begin
                  if ((wr_rs == RS_NONE) || (wr_rs == RS_ALL)) begin
                     nxt_rsp = cmd_req.wdata[RSP_BIT];
                     nxt_rs = cmd_req.wdata[RS_BIT];
                  end else begin
                     nxt_stat.invalid_data = 1'b1;
                     nxt_stat.comm_fault_summary_bit = 1'b1;
                  end
               end
               CMD_WARN_LIMIT: begin
                  if ((wr_mant < WARN_MIN) || (wr_mant > WARN_MAX) ||
                      ((wr_mant >= thermal_fault_threshold) && !limit_check_bypass)) begin
                     nxt_stat.invalid_data = 1'b1;
                     nxt_stat.comm_fault_summary_bit = 1'b1;
                  end else begin
                     nxt_warn = wr_mant;
                  end
               end
               CMD_TURN_ON_WAIT: nxt_wait = cmd_req.wdata[PROG_W-1:0];
               CMD_RAMP_TIME: nxt_ramp = cmd_req.wdata[PROG_W-1:0];
               default: begin
                  nxt_nack = 1'b1;
                  nxt_stat.invalid_command_fault = 1'b1;
                  nxt_stat.comm_fault_summary_bit = 1'b1;
               end
            endcase
         end
      end
      if (save_all_defaults) begin
         nxt_save = 1'b1;
         nxt_nvm = {ramp_ff, wait_ff};
      end
   end

   // alert follows any sticky status bit
   always_comb begin
      nxt_alert = |nxt_stat;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         warn_ff <= WARN_RESET;
         wait_ff <= WAIT_RESET;
         ramp_ff <= RAMP_RESET;
         rsp_ff <= RESP_RESET[RSP_BIT];
         rs_ff <= RESP_RESET[RS_BIT];
         init_ff <= 2'h0;
         loop_ff <= 1'b0;
         stat_ff <= '0;
         warn_lvl_ff <= 1'b0;
         done_ff <= 1'b0;
         nack_ff <= 1'b0;
         rdata_ff <= 16'h0000;
         save_ff <= 1'b0;
         nvm_ff <= '0;
         alert_ff <= 1'b0;
      end else begin
         warn_ff <= nxt_warn;
         wait_ff <= nxt_wait;
         ramp_ff <= nxt_ramp;
         rsp_ff <= nxt_rsp;
         rs_ff <= nxt_rs;
         init_ff <= nxt_init;
         loop_ff <= nxt_loop;
         stat_ff <= nxt_stat;
         warn_lvl_ff <= nxt_warn_lvl;
         done_ff <= nxt_done;
         nack_ff <= nxt_nack;
         rdata_ff <= nxt_rdata;
         save_ff <= nxt_save;
         nvm_ff <= nxt_nvm;
         alert_ff <= nxt_alert;
      end
   end

   // effective times from the bucket tables
   logic [PROG_W-1:0] wait_eff;
   logic [PROG_W-1:0] ramp_bucket;
   logic [PROG_W-1:0] ramp_eff;
   time_bucket u_wait_bucket (
      .mant(wait_ff),
      .ramp_mode(1'b0),
      .eff_ms(wait_eff)
   );
   time_bucket u_ramp_bucket (
      .mant(ramp_ff),
      .ramp_mode(1'b1),
      .eff_ms(ramp_bucket)
   );
   assign ramp_eff = loop_ff ? 7'h64 : ramp_bucket;

   // sequencer timers
   logic tick_clr;
   logic ms_tick;
   ms_tick_div #(
      .DIV(MS_CYCLES)
   ) u_ms_div (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clr(tick_clr),
      .tick(ms_tick)
   );

   seq_e seq_ff, nxt_seq;
   logic [MS_W-1:0] ms_cnt_ff, nxt_ms_cnt;
   logic [31:0] cyc_cnt_ff, nxt_cyc_cnt;
   logic [MS_W-1:0] retry_ms;
   assign retry_ms = MS_W'(ramp_eff) * RETRY_PERIODS;

   // start -> wait -> ramp -> on, with fault shutdown and retry
   always_comb begin
      nxt_seq = seq_ff;
      nxt_ms_cnt = ms_tick ? ms_cnt_ff + 10'h001 : ms_cnt_ff;
      nxt_cyc_cnt = cyc_cnt_ff + 32'h1;
      tick_clr = 1'b0;
      case (seq_ff)
         ST_OFF: begin
            tick_clr = 1'b1;
            nxt_ms_cnt = '0;
            nxt_cyc_cnt = '0;
            if (start_s && (init_ff == INIT_SETTLE)) begin
               nxt_seq = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if ((wait_eff == '0) ? (cyc_cnt_ff == 32'(SHORT_CYCLES - 1))
                                 : (nxt_ms_cnt >= MS_W'(wait_eff))) begin
               nxt_seq = ST_RAMP;
               nxt_ms_cnt = '0;
               tick_clr = 1'b1;
            end
         end
         ST_RAMP: begin
            if (nxt_ms_cnt >= MS_W'(ramp_eff)) begin
               nxt_seq = ST_ON;
            end
         end
         ST_ON: nxt_seq = ST_ON;
         ST_RETRY: begin
            if (nxt_ms_cnt >= retry_ms) begin
               nxt_seq = ST_OFF;
            end
         end
         ST_LATCHED: begin
            if (clear_faults) begin
               nxt_seq = ST_OFF;
            end
         end
         default: nxt_seq = ST_OFF;
      endcase
      if (!start_s && (seq_ff != ST_RETRY) && (seq_ff != ST_LATCHED)) begin
         nxt_seq = ST_OFF;
      end
      if (thermal_fault_level && rsp_ff && (seq_ff != ST_RETRY) && (seq_ff != ST_LATCHED)) begin
         tick_clr = 1'b1;
         nxt_ms_cnt = '0;
         nxt_seq = rs_ff ? ST_RETRY : ST_LATCHED;
      end
   end

   logic en_ff, ramp_ff_o, reg_ff;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         seq_ff <= ST_OFF;
         ms_cnt_ff <= '0;
         cyc_cnt_ff <= '0;
         en_ff <= 1'b0;
         ramp_ff_o <= 1'b0;
         reg_ff <= 1'b0;
      end else begin
         seq_ff <= nxt_seq;
         ms_cnt_ff <= nxt_ms_cnt;
         cyc_cnt_ff <= nxt_cyc_cnt;
         en_ff <= (nxt_seq == ST_RAMP) || (nxt_seq == ST_ON);
         ramp_ff_o <= nxt_seq == ST_RAMP;
         reg_ff <= nxt_seq == ST_ON;
      end
   end

   // outputs straight from flops
   assign cmd_done = done_ff;
   assign cmd_nack = nack_ff;
   assign cmd_rdata = rdata_ff;
   assign nvm_save = save_ff;
   assign nvm_data = nvm_ff;
   assign status = stat_ff;
   assign thermal_warning_level = warn_lvl_ff;
   assign smbalert = alert_ff;
   assign out_enable = en_ff;
   assign ramp_active = ramp_ff_o;
   assign in_regulation = reg_ff;
endmodule : thermal_turn_on_regs

// File: test/thermal_turn_on_regs_props.sv
// checker for the command bank, top-level ports only
// assumes one ref_clk domain with async active-low rstn
`timescale 1ns/1ps
module thermal_turn_on_regs_props
   import pwr_cmd_pkg::*;
#(
   parameter int MS_CYCLES = CYC_PER_MS,
   parameter int SHORT_CYCLES = CYC_SHORT_WAIT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // command port
   input wire logic cmd_valid,
   input wire logic cmd_done,
   input wire logic cmd_nack,
   // controls
   input wire logic clear_faults,
   input wire logic start_pin,
   input wire logic save_all_defaults,
   // observed outputs
   input wire logic nvm_save,
   input wire status_s status,
   input wire logic thermal_warning_level,
   input wire logic smbalert,
   input wire logic out_enable,
   input wire logic ramp_active,
   input wire logic in_regulation
);
   logic [15:0] start_cnt_ff;
   logic [15:0] nxt_start_cnt;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // raw start hold time; saturates so a long run never wraps
   always_comb begin
      nxt_start_cnt = start_pin ? start_cnt_ff + {15'h0, ~&start_cnt_ff} : 16'h0;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         start_cnt_ff <= 16'h0;
      end else begin
         start_cnt_ff <= nxt_start_cnt;
      end
   end

   done_after_valid_a: assert property (cmd_done |-> $past(cmd_valid))
      else $error("stray cmd_done");
   nack_with_done_a: assert property (cmd_nack |-> cmd_done)
      else $error("lone cmd_nack");
   alert_tracks_status_a: assert property (smbalert == |status)
      else $error("smbalert off status");
   warn_sets_status_a: assert property ($rose(thermal_warning_level) && !$past(clear_faults)
      |-> status.warn_status && status.temp_summary) else $error("warn status unset");
   warn_status_sticky_a: assert property ($fell(status.warn_status) |-> $past(clear_faults))
      else $error("warn status lost");
   ivc_from_nack_a: assert property ($rose(status.invalid_command_fault)
      |-> cmd_nack || $past(cmd_nack)) else $error("ivc without nack");
   ramp_drives_out_a: assert property (ramp_active |-> out_enable && !in_regulation)
      else $error("bad ramp state");
   reg_after_ramp_a: assert property ($rose(in_regulation) |-> $past(ramp_active))
      else $error("regulation skipped ramp");
   save_pulse_a: assert property (nvm_save == $past(save_all_defaults))
      else $error("nvm_save late");
   wait_min_a: assert property ($rose(out_enable) |-> start_cnt_ff >= SHORT_CYCLES)
      else $error("output rose early");
endmodule : thermal_turn_on_regs_props

bind thermal_turn_on_regs thermal_turn_on_regs_props #(
   .MS_CYCLES(MS_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)
) i_props (.*);

// File: test/cmd_host_model.sv
// host side of the command port: one word transaction per call
// assumes cmd_done is registered one cycle after the request edge
`timescale 1ns/1ps
module cmd_host_model
   import pwr_cmd_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // request
   output logic cmd_valid,
   output cmd_req_s cmd_req,
   // answer
   input wire logic cmd_done,
   input wire logic cmd_nack,
   input wire logic [15:0] cmd_rdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_req = '0;
   end

   // whole word per transfer; idle fields inverted, not stale
   task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] wd,
                       output logic [15:0] rd, output logic nk, output logic ok);
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_req = '{write: wr, code: c, wdata: wd};
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      cmd_req = ~cmd_req;
      ok = (cmd_done === 1'b1);
      rd = cmd_rdata;
      nk = cmd_nack;
   endtask : xfer
endmodule : cmd_host_model

// File: test/thermal_turn_on_regs_tb_top.sv
// self-checking bench for the thermal/turn-on command bank
// assumes the host model and bound checker; short timer counts
`timescale 1ns/1ps
module thermal_turn_on_regs_tb_top
   import pwr_cmd_pkg::*;
;
   localparam int MS = 20;
   localparam int SH = 5;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic cmd_valid, cmd_done, cmd_nack, nvm_save, smbalert;
   cmd_req_s cmd_req;
   logic [15:0] cmd_rdata;
   logic [TEMP_W-1:0] sensed_temp = 11'h019;
   logic [TEMP_W-1:0] thermal_fault_threshold = 11'h096;
   logic limit_check_bypass = 1'b0;
   logic thermal_fault_level = 1'b0;
   logic clear_faults = 1'b0;
   logic start_pin = 1'b0;
   logic loop_slave_pin = 1'b0;
   logic ss_pin_high = 1'b1;
   logic [PROG_W-1:0] ss_mantissa = 7'h09;
   logic save_all_defaults = 1'b0;
   logic [2*PROG_W-1:0] nvm_data;
   status_s status;
   logic thermal_warning_level, out_enable, ramp_active, in_regulation;
   logic [15:0] warn_exp;
   int mismatches = 0;
   int num_checks = 0;

   thermal_turn_on_regs #(.MS_CYCLES(MS), .SHORT_CYCLES(SH)) i_dut (.*);
   cmd_host_model i_host (.*);

   // 250 MHz clock
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // straps held stable from reset for the init capture
   task automatic do_reset(input logic [10:0] flt, input logic hi, input logic sl);
      rstn = 1'b0;
      thermal_fault_threshold = flt;
      ss_pin_high = hi;
      loop_slave_pin = sl;
      tick(4);
      rstn = 1'b1;
      tick(5);
   endtask : do_reset

   task automatic cmd(input logic wr, input logic [7:0] c, input logic [15:0] wd,
                      output logic [15:0] rd, output logic nk);
      logic ok;
      i_host.xfer(wr, c, wd, rd, nk, ok);
      check("cmd_done", ok, 1'b1);
   endtask : cmd

   task automatic wrd(input logic [7:0] c, input logic [15:0] wd);
      logic [15:0] rd;
      logic nk;
      cmd(1'b1, c, wd, rd, nk);
   endtask : wrd

   task automatic rdc(input logic [7:0] c, input logic [15:0] exp, input logic enk);
      logic [15:0] rd;
      logic nk;
      cmd(1'b0, c, 16'h0, rd, nk);
      check("cmd_nack", nk, enk);
      if (!enk) check("cmd_rdata", rd, exp);
   endtask : rdc

   task automatic clr();
      clear_faults = 1'b1;
      tick(1);
      clear_faults = 1'b0;
      tick(1);
   endtask : clr

   // effective ms for a programmed mantissa; ramp floors at 1 ms
   function automatic int bucket(input int m, input bit ramp);
      int lim[9] = '{9, 12, 17, 22, 32, 44, 62, 86, 127};
      int eff[9] = '{7, 10, 14, 19, 27, 37, 52, 72, 100};
      if (ramp && m <= 1) return 1;
      if (m <= 6) return m;
      for (int i = 0; i < 9; i++) if (m <= lim[i]) return eff[i];
      return 100;
   endfunction : bucket

   task automatic wait_on(output int n);
      n = 0;
      while (out_enable !== 1'b1 && n < 9000) begin
         tick(1);
         n++;
      end
   endtask : wait_on

   // one ms of slack below, 6 cycles above the wait and 4 above the ramp
   task automatic run_seq(input int we, input int re);
      int n;
      start_pin = 1'b1;
      wait_on(n);
      check("wait_time", (we == 0) ? (n >= SH && n <= SH + 6) :
            (n >= (we - 1) * MS && n <= we * MS + 6), 1'b1);
      n = 0;
      while (ramp_active === 1'b1 && n < 9000) begin
         tick(1);
         n++;
      end
      check("ramp_time", n >= (re - 1) * MS && n <= re * MS + 4, 1'b1);
      check("in_regulation", in_regulation, 1'b1);
   endtask : run_seq

   task automatic stop();
      start_pin = 1'b0;
      tick(6);
      check("out_enable", out_enable, 1'b0);
   endtask : stop

   task automatic warn_try(input int v, input int flt);
      logic ok;
      ok = v >= 100 && v <= 140 && (v < flt || limit_check_bypass);
      clr();
      wrd(CMD_WARN_LIMIT, 16'hf800 | 16'(v));
      if (ok) warn_exp = 16'(v);
      rdc(CMD_WARN_LIMIT, warn_exp, 1'b0);
      check("invalid_data", status.invalid_data, !ok);
      check("comm_summary", status.comm_fault_summary_bit, !ok);
   endtask : warn_try

   task automatic temp_step(input logic [10:0] t, input logic lvl);
      sensed_temp = t;
      tick(4);
      check("warn_level", thermal_warning_level, lvl);
   endtask : temp_step

   // watchdog, well above the run length
   initial begin
      #400000;
      mismatches++;
      end_of_test();
   end

   initial begin
      logic [15:0] wd;
      logic [15:0] rd;
      logic nk;
      int n, w, r;
      int cw[4] = '{0, 86, 87, 9};
      int cr[4] = '{0, 1, 63, 2};
      int wv[6] = '{99, 100, 141, 180, 141, 120};
      void'($urandom(32'h1abc9cce));
      do_reset(11'h096, 1'b1, 1'b0);
      rdc(CMD_WARN_LIMIT, 16'h007d, 1'b0);
      rdc(CMD_TURN_ON_WAIT, 16'h0000, 1'b0);
      rdc(CMD_RAMP_TIME, 16'h0003, 1'b0);
      rdc(CMD_FAULT_RESPONSE, 16'h00bf, 1'b0);
      rdc(8'h7f, 16'h0000, 1'b1);
      warn_exp = 16'h007d;
      repeat (6) begin
         wd = 16'($urandom);
         wrd(CMD_TURN_ON_WAIT, wd);
         rdc(CMD_TURN_ON_WAIT, {9'h0, wd[6:0]}, 1'b0);
         wrd(CMD_RAMP_TIME, ~wd);
         rdc(CMD_RAMP_TIME, {9'h0, ~wd[6:0]}, 1'b0);
      end
      foreach (wv[i]) warn_try(wv[i], 150);
      temp_step(11'h078, 1'b0);
      temp_step(11'h079, 1'b1);
      check("temp_status", {status.temp_summary, status.warn_status}, 2'b11);
      temp_step(11'h065, 1'b1);
      temp_step(11'h064, 1'b0);
      clr();
      wrd(CMD_FAULT_RESPONSE, 16'h00a8);
      check("invalid_data", status.invalid_data, 1'b1);
      rdc(CMD_FAULT_RESPONSE, 16'h00bf, 1'b0);
      for (int i = 0; i < 7; i++) begin
         w = (i < 4) ? cw[i] : $urandom_range(1, 100);
         r = (i < 4) ? cr[i] : $urandom_range(0, 40);
         wrd(CMD_TURN_ON_WAIT, 16'(w));
         wrd(CMD_RAMP_TIME, 16'(r));
         run_seq(bucket(w, 0), bucket(r, 1));
         stop();
      end
      wrd(CMD_TURN_ON_WAIT, 16'h0001);
      wrd(CMD_RAMP_TIME, 16'h0002);
      run_seq(1, 2);
      thermal_fault_level = 1'b1;
      tick(3);
      thermal_fault_level = 1'b0;
      check("out_enable", out_enable, 1'b0);
      wait_on(n);
      check("retry_time", n >= 13 * MS && n <= 15 * MS + 30, 1'b1);
      wrd(CMD_FAULT_RESPONSE, 16'h0080);
      rdc(CMD_FAULT_RESPONSE, 16'h0080, 1'b0);
      thermal_fault_level = 1'b1;
      tick(3);
      thermal_fault_level = 1'b0;
      tick(400);
      check("out_enable", out_enable, 1'b0);
      clr();
      wait_on(n);
      check("restart_time", n <= 2 * MS + 10, 1'b1);
      stop();
      wrd(CMD_TURN_ON_WAIT, 16'h0005);
      wrd(CMD_RAMP_TIME, 16'h0009);
      save_all_defaults = 1'b1;
      tick(1);
      save_all_defaults = 1'b0;
      check("nvm_save", nvm_save, 1'b1);
      check("nvm_data", nvm_data, {7'h09, 7'h05});
      do_reset(11'h06e, 1'b0, 1'b0);
      rdc(CMD_WARN_LIMIT, 16'h0064, 1'b0);
      rdc(CMD_RAMP_TIME, 16'h0009, 1'b0);
      warn_exp = 16'h0064;
      warn_try(115, 110);
      limit_check_bypass = 1'b1;
      warn_try(115, 110);
      warn_try(141, 110);
      limit_check_bypass = 1'b0;
      run_seq(0, 7);
      stop();
      do_reset(11'h096, 1'b1, 1'b1);
      rdc(CMD_TURN_ON_WAIT, 16'h0000, 1'b1);
      cmd(1'b1, CMD_RAMP_TIME, 16'h0005, rd, nk);
      check("cmd_nack", nk, 1'b1);
      check("ivc", status.invalid_command_fault, 1'b1);
      check("comm_summary", status.comm_fault_summary_bit, 1'b1);
      check("smbalert", smbalert, 1'b1);
      run_seq(0, 100);
      stop();
      end_of_test();
   end
endmodule : thermal_turn_on_regs_tb_top
